/* File: core/see_engine.v */
// Command engine of a 16 x 16 three-wire serial EEPROM
`default_nettype none
`include "see_map.vh"
// Function
// - Start bit is first serial clock rise with select and serial_in both high.
// - Nothing happens before a start bit is seen.
// - Standby ends as soon as select goes high.
// - Instructions execute only after all their bits arrive; partial ones do nothing.
// - After the last bit, clock and serial_in are ignored until select falls.
// - Programming is locked at power-up; unlock needed before erase or write.
// - Supply-good low inhibits every operation; a program cycle already running still finishes.
// - Read sends one zero dummy bit then sixteen data bits.
// - Dummy bit follows final address bit edge; later bits change after rises.
// - Output floats on the rise after the last bit or when select falls.
// - Output bit holds steady between clock edges while select stays high, except the ready rise at cycle end.
// - Read data leaves top bit first down to bit zero.
// - Word write erases the word and then programs the new data.
// - Word write is self-timed, starts after last data bit, within 2 ms.
// - Word erase sets the word to ones, self-timed, within 1 ms.
// - Erase-all sets the array to ones when unlocked, within 15 ms.
// - Write-all programs every word, no erase, within 15 ms.
// - All incoming bits are sampled on the serial clock rise.
// - Select low resets command logic; a running program cycle still finishes.
// - During a program cycle the output shows busy low, ready high.
// - Start, two opcode bits, four address bits; extended codes in top address bits.
module see_engine #(
    parameter T_WRITE_CYC = `SEE_T_WRITE_US * `SEE_CLK_MHZ,
    parameter T_ERASE_CYC = `SEE_T_ERASE_US * `SEE_CLK_MHZ,
    parameter T_ALL_CYC   = `SEE_T_ALL_US * `SEE_CLK_MHZ
) (
    // Clock and reset
    input  wire                   core_clk,
    input  wire                   srst,
    // Serial link pins
    input  wire                   chip_sel,
    input  wire                   serial_clk,
    input  wire                   serial_in,
    output reg                    serial_out,
    output reg                    serial_out_en,
    // Supply monitor
    input  wire                   supply_good,
    // Read word stream
    output reg                    rd_valid,
    input  wire                   rd_ready,
    output reg  [`SEE_WORD_W-1:0] rd_data,
    // Status
    output reg                    busy,
    output reg                    unlocked
);
    // Phase states
    localparam [2:0] ST_IDLE = 3'h0;
    localparam [2:0] ST_HDR  = 3'h1;
    localparam [2:0] ST_DATA = 3'h2;
    localparam [2:0] ST_READ = 3'h3;
    localparam [2:0] ST_DONE = 3'h4;
    localparam [2:0] ST_PROG = 3'h5;
    // Program cycle kinds
    localparam [1:0] PK_WORD  = 2'h0;
    localparam [1:0] PK_ERASE = 2'h1;
    localparam [1:0] PK_ERALL = 2'h2;
    localparam [1:0] PK_WRALL = 2'h3;

    wire [2:0] pins_s;
    wire       cs_s;
    wire       sck_s;
    wire       si_s;
    wire       pg_s;
    wire       buf_in_ready;
    wire       buf_out_valid;
    wire [`SEE_WORD_W-1:0] buf_out_data;

    reg [`SEE_WORD_W-1:0] mem_reg [0:`SEE_WORDS-1];
    reg [2:0]  state_reg;
    reg        sck_d_reg;
    reg [4:0]  bit_cnt_reg;
    reg [`SEE_HDR_BITS-1:0]  hdr_reg;
    reg [`SEE_WORD_W-1:0]    dat_reg;
    reg [`SEE_WORD_W-1:0]    shout_reg;
    reg [1:0]  pk_reg;
    reg [`SEE_ADDR_W-1:0]    pa_reg;
    reg [`SEE_WORD_W-1:0]    pd_reg;
    reg [31:0] tmr_reg;
    reg        prog_reg;
    reg        rd_push_reg;
    reg [`SEE_WORD_W-1:0] rd_word_reg;
    reg        stat_en_reg;
    integer    i;

    // Decode the two opcode bits and sub-code of a header
    function [2:0] see_kind;
        input [`SEE_HDR_BITS-1:0] h;
        begin
            case (h[`SEE_OP_HI:`SEE_OP_LO])
                `SEE_OP_READ:  see_kind = 3'h1;
                `SEE_OP_WRITE: see_kind = 3'h2;
                `SEE_OP_ERASE: see_kind = 3'h3;
                default: begin
                    case (h[`SEE_SUB_HI:`SEE_SUB_LO])
                        `SEE_SUB_UNLOCK: see_kind = 3'h4;
                        `SEE_SUB_LOCK:   see_kind = 3'h5;
                        `SEE_SUB_ERALL:  see_kind = 3'h6;
                        default:         see_kind = 3'h7;
                    endcase
                end
            endcase
        end
    endfunction

    // Pins cross into the core clock
    see_sync #(
        .W (4)
    ) u_sync (
        .core_clk (core_clk),
        .srst     (srst),
        .async_in ({supply_good, chip_sel, serial_clk, serial_in}),
        .sync_out ({pg_s, pins_s})
    );
    assign cs_s  = pins_s[2];
    assign sck_s = pins_s[1];
    assign si_s  = pins_s[0];

    // Read words buffered toward the user side
    see_buf #(
        .W (`SEE_WORD_W)
    ) u_buf (
        .core_clk  (core_clk),
        .srst      (srst),
        .in_valid  (rd_push_reg),
        .in_ready  (buf_in_ready),
        .in_data   (rd_word_reg),
        .out_valid (buf_out_valid),
        .out_ready (rd_ready | ~rd_valid),
        .out_data  (buf_out_data)
    );

    wire sck_rise = sck_s & ~sck_d_reg;
    wire [2:0] hk = see_kind({hdr_reg[`SEE_HDR_BITS-2:0], si_s});
    wire [`SEE_ADDR_W-1:0] hadr = {hdr_reg[2:0], si_s};

    // Serial command front end
    always @(posedge core_clk) begin
        if (srst) begin
            state_reg     <= ST_IDLE;
            sck_d_reg     <= 1'b0;
            bit_cnt_reg   <= 5'h0;
            hdr_reg       <= {`SEE_HDR_BITS{1'b0}};
            dat_reg       <= {`SEE_WORD_W{1'b0}};
            shout_reg     <= {`SEE_WORD_W{1'b0}};
            serial_out    <= 1'b0;
            serial_out_en <= 1'b0;
            unlocked      <= `SEE_UNLOCK_RST;
            rd_push_reg   <= 1'b0;
            rd_word_reg   <= {`SEE_WORD_W{1'b0}};
            prog_reg      <= 1'b0;
            pk_reg        <= PK_WORD;
            pa_reg        <= {`SEE_ADDR_W{1'b0}};
            pd_reg        <= {`SEE_WORD_W{1'b0}};
            stat_en_reg   <= 1'b0;
        end else begin
            sck_d_reg <= sck_s;
            prog_reg  <= 1'b0;
            if (rd_push_reg & buf_in_ready)
                rd_push_reg <= 1'b0;
            if (!pg_s) begin
                state_reg     <= ST_IDLE;
                serial_out_en <= 1'b0;
                unlocked      <= `SEE_UNLOCK_RST;
            end else if (!cs_s) begin
                // Deselect resets the front end but not a running cycle
                serial_out_en <= 1'b0;
                stat_en_reg   <= busy;
                if (state_reg != ST_PROG || !busy)
                    state_reg <= busy ? ST_PROG : ST_IDLE;
            end else begin
                case (state_reg)
                    ST_IDLE: begin
                        if (sck_rise && si_s) begin
                            state_reg   <= ST_HDR;
                            bit_cnt_reg <= 5'h0;
                        end
                    end
                    ST_HDR: begin
                        if (sck_rise) begin
                            hdr_reg     <= {hdr_reg[`SEE_HDR_BITS-2:0], si_s};
                            bit_cnt_reg <= bit_cnt_reg + 5'h1;
                            if (bit_cnt_reg == 5'h5) begin
                                bit_cnt_reg <= 5'h0;
                                pa_reg      <= hadr;
                                case (hk)
                                    3'h1: begin
                                        state_reg     <= ST_READ;
                                        shout_reg     <= mem_reg[hadr];
                                        serial_out    <= 1'b0;
                                        serial_out_en <= 1'b1;
                                        rd_word_reg   <= mem_reg[hadr];
                                        rd_push_reg   <= 1'b1;
                                    end
                                    3'h2, 3'h7: state_reg <= ST_DATA;
                                    3'h3: begin
                                        pk_reg    <= PK_ERASE;
                                        prog_reg  <= unlocked;
                                        state_reg <= unlocked ? ST_PROG : ST_DONE;
                                    end
                                    3'h4: begin
                                        unlocked  <= 1'b1;
                                        state_reg <= ST_DONE;
                                    end
                                    3'h5: begin
                                        unlocked  <= 1'b0;
                                        state_reg <= ST_DONE;
                                    end
                                    default: begin
                                        pk_reg    <= PK_ERALL;
                                        prog_reg  <= unlocked;
                                        state_reg <= unlocked ? ST_PROG : ST_DONE;
                                    end
                                endcase
                            end
                        end
                    end
                    ST_DATA: begin
                        if (sck_rise) begin
                            dat_reg     <= {dat_reg[`SEE_WORD_W-2:0], si_s};
                            bit_cnt_reg <= bit_cnt_reg + 5'h1;
                            if (bit_cnt_reg == 5'hf) begin
                                pd_reg    <= {dat_reg[`SEE_WORD_W-2:0], si_s};
                                pk_reg    <= (hdr_reg[`SEE_OP_HI:`SEE_OP_LO] == `SEE_OP_WRITE) ?
                                             PK_WORD : PK_WRALL;
                                prog_reg  <= unlocked;
                                state_reg <= unlocked ? ST_PROG : ST_DONE;
                            end
                        end
                    end
                    ST_READ: begin
                        if (sck_rise) begin
                            bit_cnt_reg <= bit_cnt_reg + 5'h1;
                            if (bit_cnt_reg == 5'h10) begin
                                serial_out_en <= 1'b0;
                                state_reg     <= ST_DONE;
                            end else begin
                                serial_out <= shout_reg[`SEE_WORD_W-1];
                                shout_reg  <= {shout_reg[`SEE_WORD_W-2:0], 1'b0};
                            end
                        end
                    end
                    ST_PROG: begin
                        // New starts ignored until the cycle ends
                        serial_out    <= ~busy;
                        serial_out_en <= stat_en_reg;
                        if (!busy && !prog_reg)
                            state_reg <= ST_DONE;
                    end
                    ST_DONE: begin
                        serial_out <= 1'b1;
                    end
                    default: state_reg <= ST_IDLE;
                endcase
            end
        end
    end

    // Self-timed program cycle and array update
    always @(posedge core_clk) begin
        if (srst) begin
            busy    <= 1'b0;
            tmr_reg <= 32'h0;
        end else if (prog_reg) begin
            busy <= 1'b1;
            case (pk_reg)
                PK_WORD:  tmr_reg <= T_WRITE_CYC - 1;
                PK_ERASE: tmr_reg <= T_ERASE_CYC - 1;
                default:  tmr_reg <= T_ALL_CYC - 1;
            endcase
        end else if (busy) begin
            if (tmr_reg == 32'h0) begin
                busy <= 1'b0;
                case (pk_reg)
                    PK_WORD:  mem_reg[pa_reg] <= pd_reg;
                    PK_ERASE: mem_reg[pa_reg] <= `SEE_ERASED_WORD;
                    PK_ERALL: for (i = 0; i < `SEE_WORDS; i = i + 1) mem_reg[i] <= `SEE_ERASED_WORD;
                    default:  for (i = 0; i < `SEE_WORDS; i = i + 1) mem_reg[i] <= pd_reg;
                endcase
            end else begin
                tmr_reg <= tmr_reg - 32'h1;
            end
        end
    end

    // Buffered read words presented from flops; valid never waits for ready
    always @(posedge core_clk) begin
        if (srst) begin
            rd_valid <= 1'b0;
            rd_data  <= {`SEE_WORD_W{1'b0}};
        end else if (!rd_valid || rd_ready) begin
            rd_valid <= buf_out_valid;
            if (buf_out_valid)
                rd_data <= buf_out_data;
        end
    end
endmodule
`default_nettype wire

/* File: core/see_map.vh */
// Constants of the serial EEPROM command engine
`ifndef SEE_MAP_VH
`define SEE_MAP_VH
// Array shape
`define SEE_WORD_W        16
`define SEE_ADDR_W        4
`define SEE_WORDS         16
`define SEE_ERASED_WORD   16'hffff
// Instruction field positions within the 6-bit opcode/address shift
`define SEE_OP_HI         5
`define SEE_OP_LO         4
`define SEE_SUB_HI        3
`define SEE_SUB_LO        2
`define SEE_HDR_BITS      6
// Opcodes
`define SEE_OP_EXT        2'h0
`define SEE_OP_WRITE      2'h1
`define SEE_OP_READ       2'h2
`define SEE_OP_ERASE      2'h3
// Extended sub-codes
`define SEE_SUB_LOCK      2'h0
`define SEE_SUB_WRALL     2'h1
`define SEE_SUB_ERALL     2'h2
`define SEE_SUB_UNLOCK    2'h3
// Cycle times in microseconds, core clock in MHz
`define SEE_CLK_MHZ       100
`define SEE_T_WRITE_US    2000
`define SEE_T_ERASE_US    1000
`define SEE_T_ALL_US      15000
// Programming lock state after power-up
`define SEE_UNLOCK_RST    1'b0
`endif

/* File: core/see_sync.v */
// Two-flop synchroniser for asynchronous pin inputs
`default_nettype none
module see_sync #(
    parameter W = 1
) (
    // Clock and reset
    input  wire         core_clk,
    input  wire         srst,
    // Data
    input  wire [W-1:0] async_in,
    output reg  [W-1:0] sync_out
);
    reg [W-1:0] meta_reg;

    // First stage is read only by the second
    always @(posedge core_clk) begin
        if (srst) begin
            meta_reg <= {W{1'b0}};
            sync_out <= {W{1'b0}};
        end else begin
            meta_reg <= async_in;
            sync_out <= meta_reg;
        end
    end
endmodule
`default_nettype wire

/* File: core/see_buf.v */
// Two-entry valid/ready buffer for read data words
`default_nettype none
module see_buf #(
    parameter W = 16
) (
    // Clock and reset
    input  wire         core_clk,
    input  wire         srst,
    // Fill side
    input  wire         in_valid,
    output wire         in_ready,
    input  wire [W-1:0] in_data,
    // Drain side
    output wire         out_valid,
    input  wire         out_ready,
    output wire [W-1:0] out_data
);
    reg [W-1:0] mem_reg [0:1];
    reg         wp_reg;
    reg         rp_reg;
    reg [1:0]   cnt_reg;
    wire        push;
    wire        pop;

    assign in_ready  = (cnt_reg != 2'h2);
    assign out_valid = (cnt_reg != 2'h0);
    assign out_data  = mem_reg[rp_reg];
    assign push      = in_valid & in_ready;
    assign pop       = out_valid & out_ready;

    // Pointers and occupancy
    always @(posedge core_clk) begin
        if (srst) begin
            wp_reg  <= 1'b0;
            rp_reg  <= 1'b0;
            cnt_reg <= 2'h0;
        end else begin
            if (push)
                wp_reg <= ~wp_reg;
            if (pop)
                rp_reg <= ~rp_reg;
            if (push & ~pop)
                cnt_reg <= cnt_reg + 2'h1;
            else if (pop & ~push)
                cnt_reg <= cnt_reg - 2'h1;
        end
    end

    // Storage
    always @(posedge core_clk) begin
        if (push)
            mem_reg[wp_reg] <= in_data;
    end
endmodule
`default_nettype wire

/* File: verif/see_engine_properties.sv */
// Concurrent checks on the serial EEPROM command engine ports
`default_nettype none
module see_engine_properties (
    // Clock and reset
    input wire logic        core_clk,
    input wire logic        srst,
    // Link pins and supply
    input wire logic        chip_sel,
    input wire logic        serial_clk,
    input wire logic        serial_in,
    input wire logic        serial_out,
    input wire logic        serial_out_en,
    input wire logic        supply_good,
    // Word stream and status
    input wire logic        rd_valid,
    input wire logic        rd_ready,
    input wire logic [15:0] rd_data,
    input wire logic        busy,
    input wire logic        unlocked
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking @(posedge core_clk); endclocking
    default disable iff (srst);
    // Deselect long enough to pass the pin synchroniser
    sequence s_desel; !chip_sel [*6]; endsequence
    // Supply low long enough to pass the synchroniser
    sequence s_nosupply; !supply_good [*6]; endsequence
    // Link clock frozen while selected and idle
    sequence s_frozen; (chip_sel && !busy && $stable(serial_clk)) [*8]; endsequence
    // Program cycle: at least eight busy cycles, then bounded end
    sequence s_cycle; busy [*8] ##[1:960] !busy; endsequence
    chk_float_desel: assert property (s_desel |-> !serial_out_en)
        else $error("data out driven while deselected");
    chk_supply_relock: assert property (s_nosupply |-> !unlocked)
        else $error("unlocked without supply");
    chk_supply_idle: assert property (s_nosupply |=> !$rose(busy))
        else $error("cycle started without supply");
    chk_lock_prog: assert property (!unlocked |=> !$rose(busy))
        else $error("cycle started while locked");
    chk_cycle_len: assert property ($rose(busy) |-> s_cycle)
        else $error("program cycle length wrong");
    chk_dummy_zero: assert property ($rose(serial_out_en) |-> !serial_out)
        else $error("first driven bit not zero");
    chk_status_busy: assert property (busy && serial_out_en |-> !serial_out)
        else $error("status high while busy");
    chk_hold_frozen: assert property (s_frozen |-> $stable(serial_out) && $stable(serial_out_en))
        else $error("data out moved without clock");
    chk_word_held: assert property (rd_valid && !rd_ready |=> rd_valid && $stable(rd_data))
        else $error("stream word dropped while stalled");
    chk_no_read_busy: assert property (busy |-> !$rose(rd_valid))
        else $error("read served during cycle");
endmodule
`default_nettype wire

/* File: verif/see_host.sv */
// Controller model driving the three-wire serial link
`default_nettype none
module see_host (
    // Link pins
    output logic      chip_sel,
    output logic      serial_clk,
    output logic      serial_in,
    input wire logic  serial_out,
    input wire logic  serial_out_en
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [31:0] so_seen;
    logic [31:0] oe_seen;
    // Idle link: deselected, clock still
    initial begin
        chip_sel = 1'b0;
        serial_clk = 1'b0;
        serial_in = 1'b0;
    end
    // Frame of z idle rises then n rises; first cut bits of f sent top first, samples taken before each rise
    task automatic frame(input logic [22:0] f, input int z, input int n, input int cut, input bit pause);
        int i;
        chip_sel = 1'b1;
        for (i = 0; i < z + n; i++) begin
            if (i < z) serial_in = 1'b0;
            else if (i - z < cut) serial_in = f[22 - (i - z)];
            else serial_in = ~serial_in;
            #62.5;
            so_seen[i] = serial_out;
            oe_seen[i] = serial_out_en;
            serial_clk = 1'b1;
            if (pause && i == z + 12) #500;
            #62.5;
            serial_clk = 1'b0;
        end
        #62.5;
        chip_sel = 1'b0;
        serial_in = ~serial_in;
        #200;
    endtask
endmodule
`default_nettype wire

/* File: verif/see_engine_test.sv */
// Self-checking bench for the serial EEPROM command engine
`default_nettype none
module see_engine_test;
    timeunit 1ns;
    timeprecision 100ps;
    logic        core_clk, srst, supply_good, rd_ready, stall, busy_seen;
    wire         chip_sel, serial_clk, serial_in, serial_out, serial_out_en, rd_valid, busy, unlocked;
    wire  [15:0] rd_data;
    logic [15:0] mem [16];
    logic [15:0] got_q [$];
    logic [15:0] d;
    logic [3:0]  a;
    int          n_fail, cmp_count, seed, i, k, z;

    see_engine #(.T_WRITE_CYC(800), .T_ERASE_CYC(600), .T_ALL_CYC(900)) dut (
        .core_clk(core_clk), .srst(srst), .chip_sel(chip_sel), .serial_clk(serial_clk),
        .serial_in(serial_in), .serial_out(serial_out), .serial_out_en(serial_out_en),
        .supply_good(supply_good), .rd_valid(rd_valid), .rd_ready(rd_ready), .rd_data(rd_data),
        .busy(busy), .unlocked(unlocked));
    see_host host (.chip_sel(chip_sel), .serial_clk(serial_clk), .serial_in(serial_in),
        .serial_out(serial_out), .serial_out_en(serial_out_en));

    // Core clock
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    // Stream sink with random stalls, and busy watcher
    always @(posedge core_clk) begin
        if (rd_valid === 1'b1 && rd_ready === 1'b1) got_q.push_back(rd_data);
        if (busy === 1'b1) busy_seen <= 1'b1;
        rd_ready <= #1 !stall && ($random(seed) & 1);
    end
    // Comparison with mismatch report
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("unexpected %s: expected %h, seen %h", what, exp, seen);
        end
    endtask
    // Instruction frame: start, opcode, address, data
    function automatic logic [22:0] cmd(input logic [1:0] op, input logic [3:0] ad, input logic [15:0] dt);
        return {1'b1, op, ad, dt};
    endfunction
    // Programming command, then wait for the cycle to end
    task automatic prog(input logic [22:0] f, input int cut, input bit want);
        int t;
        busy_seen = 1'b0;
        host.frame(f, 0, cut, cut, 1'b0);
        for (t = 0; t < 1000 && busy !== 1'b0; t++) @(posedge core_clk);
        check("program cycle", {busy_seen, busy}, {want, 1'b0});
    endtask
    // Read with random idle prefix; compares pin bits and optionally the stream word
    task automatic rd(input logic [3:0] ad, input logic [15:0] exp, input bit pause, input bit pop);
        int t;
        z = $random(seed) & 3;
        host.frame(cmd(2'h2, ad, 16'h0), z, 25, 7, pause);
        check("drive window", {host.oe_seen[z+6], host.oe_seen[z+7], host.oe_seen[z+24]}, 3'b010);
        check("dummy bit", host.so_seen[z+7], 1'b0);
        for (t = 0; t < 16; t++) check("data bit", host.so_seen[z+8+t], exp[15-t]);
        for (t = 0; t < 50 && pop && got_q.size() == 0; t++) @(posedge core_clk);
        if (pop) check("stream word", got_q.size() ? got_q.pop_front() : 16'hxxxx, exp);
    endtask
    // Closing report and verdict
    task automatic wrap_up;
        $display("compares %0d, mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    // Watchdog
    initial begin
        #900000;
        n_fail++;
        wrap_up;
    end
    // Main sequence
    initial begin
        seed = 25; srst = 1'b1; supply_good = 1'b0; stall = 1'b0; rd_ready = 1'b0; busy_seen = 1'b0;
        n_fail = 0; cmp_count = 0;
        repeat (8) @(posedge core_clk);
        #1 srst = 1'b0;
        repeat (4) @(posedge core_clk);
        host.frame(cmd(2'h0, 4'hc, 16'h0), 0, 7, 7, 1'b0);
        prog(cmd(2'h0, 4'h8, 16'h0), 7, 1'b0);
        check("lock state", unlocked, 1'b0);
        supply_good = 1'b1;
        prog(cmd(2'h3, 4'h0, 16'h0), 7, 1'b0);
        host.frame(cmd(2'h0, 4'hc, 16'h0), 0, 7, 7, 1'b0);
        check("lock state", unlocked, 1'b1);
        prog(cmd(2'h0, 4'h8, 16'h0), 7, 1'b1);
        rd(4'h5, 16'hffff, 1'b0, 1'b1);
        d = 16'($random(seed));
        prog(cmd(2'h0, 4'h4, d), 23, 1'b1);
        for (i = 0; i < 16; i++) mem[i] = d;
        rd(4'hb, d, 1'b0, 1'b1);
        // Random word writes with read-back, some with the link clock paused
        for (k = 0; k < 6; k++) begin
            a = 4'($random(seed));
            d = 16'($random(seed));
            prog(cmd(2'h1, a, d), 23, 1'b1);
            mem[a] = d;
            rd(a, d, k[0], 1'b1);
        end
        prog(cmd(2'h3, a, 16'h0), 7, 1'b1);
        rd(a, 16'hffff, 1'b0, 1'b1);
        prog(cmd(2'h1, a, 16'h1234), 22, 1'b0);
        rd(a, 16'hffff, 1'b0, 1'b1);
        // Read attempted during a write cycle shows status and is ignored
        host.frame(cmd(2'h1, a, 16'h5a5a), 0, 23, 23, 1'b0);
        host.frame(cmd(2'h2, a, 16'h0), 0, 25, 7, 1'b0);
        check("status pin", {host.oe_seen[3], host.so_seen[3]}, 2'b10);
        check("words during cycle", got_q.size(), 0);
        for (i = 0; i < 1000 && busy !== 1'b0; i++) @(posedge core_clk);
        rd(a, 16'h5a5a, 1'b0, 1'b1);
        // Supply loss relocks; writes then refused
        supply_good = 1'b0;
        repeat (10) @(posedge core_clk);
        #1 supply_good = 1'b1;
        check("lock state", unlocked, 1'b0);
        prog(cmd(2'h1, a, 16'h0), 23, 1'b0);
        host.frame(cmd(2'h0, 4'hc, 16'h0), 0, 7, 7, 1'b0);
        host.frame(cmd(2'h0, 4'h0, 16'h0), 0, 7, 7, 1'b0);
        check("lock state", unlocked, 1'b0);
        // Two words held while the receiver stalls, then drained in order
        @(posedge core_clk);
        #1 stall = 1'b1;
        rd(a, 16'h5a5a, 1'b0, 1'b0);
        rd(4'h3, mem[3], 1'b0, 1'b0);
        check("held word", rd_valid, 1'b1);
        #1 stall = 1'b0;
        for (i = 0; i < 50 && got_q.size() < 2; i++) @(posedge core_clk);
        check("stalled words", got_q.size(), 2);
        check("stalled first", got_q.size() ? got_q.pop_front() : 16'hxxxx, 16'h5a5a);
        check("stalled second", got_q.size() ? got_q.pop_front() : 16'hxxxx, mem[3]);
        wrap_up;
    end
endmodule
bind see_engine see_engine_properties chk (
    .core_clk(core_clk), .srst(srst), .chip_sel(chip_sel), .serial_clk(serial_clk),
    .serial_in(serial_in), .serial_out(serial_out), .serial_out_en(serial_out_en),
    .supply_good(supply_good), .rd_valid(rd_valid), .rd_ready(rd_ready), .rd_data(rd_data),
    .busy(busy), .unlocked(unlocked));
`default_nettype wire
